// File: rtl/rol_pkg.sv
// Constants, register map and field layout for the relay output latch block.
// Assumes a single 40 MHz clock and a plain strobe register port.
package rol_pkg;
   // Clock and timebase
   localparam int CLK_PERIOD_PS = 25_000;
   localparam int TICK_TIME_NS = 1_000_000;
   localparam int TICK_CYCLES = (TICK_TIME_NS * 1000) / CLK_PERIOD_PS;
   localparam int FIXED_DEB_TIME_MS = 12;
   localparam int FIXED_DEB_TICKS = (FIXED_DEB_TIME_MS * 1_000_000)
      / TICK_TIME_NS;

   // Sizes
   localparam int NUM_DI = 8;
   localparam int NUM_EXT = 7;
   localparam int NUM_OUT = 4;
   localparam int NUM_SLOT = 7;
   localparam int SEL_W = 4;
   localparam int TIME_W = 16;
   localparam int ADDR_W = 8;
   localparam int POOL_W = 1 + NUM_DI + NUM_EXT;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_ACK_CMD = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_OVERRIDE = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_DI_DEB0 = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_DI_INV = 8'h30;
   localparam logic [ADDR_W-1:0] OFF_OUT0 = 8'h40;
   localparam logic [ADDR_W-1:0] OUT_STRIDE = 8'h10;
   localparam logic [ADDR_W-1:0] OUT_SLOT_OFF = 8'h00;
   localparam logic [ADDR_W-1:0] OUT_CFG_OFF = 8'h04;
   localparam logic [ADDR_W-1:0] OUT_TIME_OFF = 8'h08;

   // Field positions
   localparam int CTRL_REMOTE_EN_BIT = 0;
   localparam int ACK_SCADA_BIT = 0;
   localparam int OVR_FORCE_EN_LSB = 0;
   localparam int OVR_FORCE_VAL_LSB = 4;
   localparam int OVR_DISARM_LSB = 8;
   localparam int CFG_SLOT_INV_LSB = 0;
   localparam int CFG_COL_INV_BIT = 8;
   localparam int CFG_LATCH_BIT = 9;
   localparam int CFG_ACK_SEL_LSB = 12;
   localparam int TIME_HOLD_LSB = 0;
   localparam int TIME_OFF_LSB = 16;
   localparam int STAT_CONTACT_LSB = 0;
   localparam int STAT_LATCH_LSB = 4;
   localparam int STAT_SYSOK_BIT = 8;
   localparam int STAT_DI_LSB = 16;

   // Reset values
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam logic [TIME_W-1:0] RST_DEB_TICKS = 16'h000a;
endpackage : rol_pkg

// File: rtl/rol_relay_output.sv
// Relay output contacts with debounced inputs, latching and system-OK.
// Assumes one 40 MHz clock; ext_sig, boot_done and internal_fault come
// from logic on that clock, the raw inputs and key pins do not.
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module rol_relay_output
   import rol_pkg::*;
#(
   parameter int TICK_LEN = TICK_CYCLES
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Field inputs and trigger sources
   input wire logic [NUM_DI-1:0] di_raw,
   input wire logic [NUM_EXT-1:0] ext_sig,
   input wire logic panel_clear_key,
   input wire logic global_output_ack,
   // Device state
   input wire logic boot_done,
   input wire logic internal_fault,
   // Non-volatile latch image
   input wire logic [NUM_OUT-1:0] nv_latch_in,
   output logic [NUM_OUT-1:0] nv_latch_out,
   // Contacts and indicators
   output logic [NUM_OUT-1:0] contact,
   output logic system_ok_contact,
   output logic system_ok_led,
   output logic [NUM_DI-1:0] di_level
);

   function automatic logic time_done(input logic [TIME_W-1:0] cnt,
      input logic [TIME_W-1:0] lim);
      time_done = (cnt >= lim);
   endfunction : time_done

   function automatic logic [TIME_W-1:0] time_step(
      input logic [TIME_W-1:0] cnt, input logic tick);
      if (tick && cnt != {TIME_W{1'b1}})
      begin
         time_step = cnt + 16'h0001;
      end
      else
      begin
         time_step = cnt;
      end
   endfunction : time_step

   localparam logic [TIME_W-1:0] FIXED_LIM = TIME_W'(FIXED_DEB_TICKS);
   localparam logic [31:0] TICK_LAST = 32'(TICK_LEN - 1);

   // Configuration registers
   logic remote_en_q;
   logic scada_ack_q;
   logic [NUM_OUT-1:0] force_en_q;
   logic [NUM_OUT-1:0] force_val_q;
   logic [NUM_OUT-1:0] disarm_q;
   logic [TIME_W-1:0] deb_lim_q [NUM_DI];
   logic [NUM_DI-1:0] di_inv_q;
   logic [SEL_W*NUM_SLOT-1:0] slot_sel_q [NUM_OUT];
   logic [NUM_SLOT-1:0] slot_inv_q [NUM_OUT];
   logic [NUM_OUT-1:0] col_inv_q;
   logic [NUM_OUT-1:0] latch_en_q;
   logic [NUM_OUT-1:0] cfg_seen_q;
   logic [SEL_W-1:0] ack_sel_q [NUM_OUT];
   logic [TIME_W-1:0] hold_lim_q [NUM_OUT];
   logic [TIME_W-1:0] off_lim_q [NUM_OUT];

   // Timebase
   logic [31:0] tick_cnt_q;
   logic tick_q;

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n || tick_cnt_q >= TICK_LAST)
      begin
         tick_cnt_q <= 32'h0000_0000;
      end
      else
      begin
         tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
      end
      tick_q <= reset_n && (tick_cnt_q >= TICK_LAST);
   end

   // Synchronisers for pins
   logic [NUM_DI+1:0] pin_s1_q;
   logic [NUM_DI+1:0] pin_s2_q;
   logic [NUM_DI-1:0] di_prev_q;
   logic key_s;
   logic gack_s;

   always_ff @(posedge ref_clk)
   begin
      pin_s1_q <= {global_output_ack, panel_clear_key, di_raw};
      pin_s2_q <= pin_s1_q;
      di_prev_q <= pin_s2_q[NUM_DI-1:0];
   end

   assign key_s = pin_s2_q[NUM_DI];
   assign gack_s = pin_s2_q[NUM_DI+1];

   // Two-stage debounce per input
   logic [TIME_W-1:0] fix_cnt_q [NUM_DI];
   logic [NUM_DI-1:0] fix_lvl_q;
   logic [NUM_DI-1:0] fix_prev_q;
   logic [TIME_W-1:0] cfg_cnt_q [NUM_DI];
   logic [NUM_DI-1:0] cfg_lvl_q;

   always_ff @(posedge ref_clk)
   begin
      fix_prev_q <= fix_lvl_q;
      for (int i = 0; i < NUM_DI; i++)
      begin
         if (!reset_n)
         begin
            fix_cnt_q[i] <= '0;
            fix_lvl_q[i] <= 1'b0;
            cfg_cnt_q[i] <= '0;
            cfg_lvl_q[i] <= 1'b0;
         end
         else
         begin
            if (pin_s2_q[i] != di_prev_q[i])
            begin
               fix_cnt_q[i] <= '0;
            end
            else if (time_done(fix_cnt_q[i], FIXED_LIM))
            begin
               fix_lvl_q[i] <= pin_s2_q[i];
            end
            else
            begin
               fix_cnt_q[i] <= time_step(fix_cnt_q[i], tick_q);
            end
            if (fix_lvl_q[i] != fix_prev_q[i])
            begin
               cfg_cnt_q[i] <= '0;
            end
            else if (time_done(cfg_cnt_q[i], deb_lim_q[i]))
            begin
               cfg_lvl_q[i] <= fix_lvl_q[i];
            end
            else
            begin
               cfg_cnt_q[i] <= time_step(cfg_cnt_q[i], tick_q);
            end
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         di_level <= '0;
      end
      else
      begin
         di_level <= cfg_lvl_q ^ di_inv_q;
      end
   end

   // Trigger pool: index 0 means unassigned
   logic [POOL_W-1:0] pool;
   assign pool = {ext_sig, di_level, 1'b0};

   logic [NUM_OUT-1:0] combined;
   logic [NUM_OUT-1:0] any_assigned;
   logic [NUM_OUT-1:0] ack_hit;

   always_comb
   begin
      logic [SEL_W-1:0] sel;
      logic or_acc;
      sel = '0;
      or_acc = 1'b0;
      for (int k = 0; k < NUM_OUT; k++)
      begin
         or_acc = 1'b0;
         any_assigned[k] = 1'b0;
         for (int s = 0; s < NUM_SLOT; s++)
         begin
            sel = slot_sel_q[k][s*SEL_W +: SEL_W];
            if (sel != '0)
            begin
               any_assigned[k] = 1'b1;
               or_acc = or_acc | (pool[sel] ^ slot_inv_q[k][s]);
            end
         end
         combined[k] = any_assigned[k] & (or_acc ^ col_inv_q[k]);
         ack_hit[k] = key_s
            | (latch_en_q[k] & (ack_sel_q[k] != '0) & pool[ack_sel_q[k]])
            | (remote_en_q & (gack_s | scada_ack_q));
      end
   end

   // Latch, off-delay and hold per output
   logic [NUM_OUT-1:0] latch_q;
   logic [TIME_W-1:0] off_cnt_q [NUM_OUT];
   logic [TIME_W-1:0] hold_cnt_q [NUM_OUT];
   logic [NUM_OUT-1:0] target;

   always_ff @(posedge ref_clk)
   begin
      for (int k = 0; k < NUM_OUT; k++)
      begin
         if (!reset_n)
         begin
            latch_q[k] <= nv_latch_in[k];
            off_cnt_q[k] <= '0;
         end
         else
         begin
            if (combined[k])
            begin
               off_cnt_q[k] <= '0;
            end
            else
            begin
               off_cnt_q[k] <= time_step(off_cnt_q[k], tick_q);
            end
            if (!latch_en_q[k] || !any_assigned[k])
            begin
               // Restored image survives until this output is set up
               if (cfg_seen_q[k])
               begin
                  latch_q[k] <= 1'b0;
               end
            end
            else if (combined[k])
            begin
               latch_q[k] <= 1'b1;
            end
            else if (ack_hit[k] && time_done(off_cnt_q[k], off_lim_q[k]))
            begin
               latch_q[k] <= 1'b0;
            end
         end
      end
   end

   assign target = (latch_en_q & latch_q) | (~latch_en_q & combined);

   always_ff @(posedge ref_clk)
   begin
      nv_latch_out <= reset_n ? latch_q : nv_latch_in;
      for (int k = 0; k < NUM_OUT; k++)
      begin
         if (!reset_n)
         begin
            contact[k] <= 1'b0;
            hold_cnt_q[k] <= '0;
         end
         else if (disarm_q[k] || force_en_q[k])
         begin
            contact[k] <= force_val_q[k] & ~disarm_q[k];
            hold_cnt_q[k] <= '0;
         end
         else if (target[k] != contact[k]
            && time_done(hold_cnt_q[k], hold_lim_q[k]))
         begin
            contact[k] <= target[k];
            hold_cnt_q[k] <= '0;
         end
         else
         begin
            hold_cnt_q[k] <= time_step(hold_cnt_q[k], tick_q);
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         system_ok_contact <= 1'b0;
         system_ok_led <= 1'b0;
      end
      else
      begin
         system_ok_contact <= boot_done & ~internal_fault;
         system_ok_led <= boot_done & ~internal_fault;
      end
   end

   // Register writes
   logic [ADDR_W-1:0] out_rel;
   logic [ADDR_W-1:0] out_idx;
   logic [ADDR_W-1:0] out_sub;
   logic out_hit;
   logic di_hit;
   logic [ADDR_W-1:0] di_rel;

   assign out_rel = reg_addr - OFF_OUT0;
   assign out_idx = out_rel >> 4;
   assign out_sub = out_rel & (OUT_STRIDE - 8'h01);
   assign out_hit = (reg_addr >= OFF_OUT0)
      && (out_idx < ADDR_W'(NUM_OUT));
   assign di_rel = (reg_addr - OFF_DI_DEB0) >> 2;
   assign di_hit = (reg_addr >= OFF_DI_DEB0) && (reg_addr < OFF_DI_INV);

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         remote_en_q <= 1'b0;
         scada_ack_q <= 1'b0;
         force_en_q <= '0;
         force_val_q <= '0;
         disarm_q <= '0;
         di_inv_q <= '0;
         cfg_seen_q <= '0;
         for (int i = 0; i < NUM_DI; i++)
         begin
            deb_lim_q[i] <= RST_DEB_TICKS;
         end
         for (int k = 0; k < NUM_OUT; k++)
         begin
            slot_sel_q[k] <= '0;
            slot_inv_q[k] <= '0;
            col_inv_q[k] <= 1'b0;
            latch_en_q[k] <= 1'b0;
            ack_sel_q[k] <= '0;
            hold_lim_q[k] <= '0;
            off_lim_q[k] <= '0;
         end
      end
      else
      begin
         scada_ack_q <= reg_wr && reg_addr == OFF_ACK_CMD
            && reg_wdata[ACK_SCADA_BIT];
         if (reg_wr && reg_addr == OFF_CTRL)
         begin
            remote_en_q <= reg_wdata[CTRL_REMOTE_EN_BIT];
         end
         if (reg_wr && reg_addr == OFF_OVERRIDE)
         begin
            force_en_q <= reg_wdata[OVR_FORCE_EN_LSB +: NUM_OUT];
            force_val_q <= reg_wdata[OVR_FORCE_VAL_LSB +: NUM_OUT];
            disarm_q <= reg_wdata[OVR_DISARM_LSB +: NUM_OUT];
         end
         if (reg_wr && reg_addr == OFF_DI_INV)
         begin
            di_inv_q <= reg_wdata[NUM_DI-1:0];
         end
         for (int i = 0; i < NUM_DI; i++)
         begin
            if (reg_wr && di_hit && di_rel == ADDR_W'(i))
            begin
               deb_lim_q[i] <= reg_wdata[TIME_W-1:0];
            end
         end
         for (int k = 0; k < NUM_OUT; k++)
         begin
            if (reg_wr && out_hit && out_idx == ADDR_W'(k))
            begin
               if (out_sub == OUT_SLOT_OFF)
               begin
                  slot_sel_q[k] <= reg_wdata[SEL_W*NUM_SLOT-1:0];
               end
               if (out_sub == OUT_CFG_OFF)
               begin
                  slot_inv_q[k] <= reg_wdata[CFG_SLOT_INV_LSB +: NUM_SLOT];
                  col_inv_q[k] <= reg_wdata[CFG_COL_INV_BIT];
                  latch_en_q[k] <= reg_wdata[CFG_LATCH_BIT];
                  ack_sel_q[k] <= reg_wdata[CFG_ACK_SEL_LSB +: SEL_W];
                  cfg_seen_q[k] <= 1'b1;
               end
               if (out_sub == OUT_TIME_OFF)
               begin
                  hold_lim_q[k] <= reg_wdata[TIME_HOLD_LSB +: TIME_W];
                  off_lim_q[k] <= reg_wdata[TIME_OFF_LSB +: TIME_W];
               end
            end
         end
      end
   end

   // Register reads, data one cycle after the strobe
   logic [31:0] rd_mux;

   always_comb
   begin
      rd_mux = RST_ZERO;
      if (reg_addr == OFF_CTRL)
      begin
         rd_mux[CTRL_REMOTE_EN_BIT] = remote_en_q;
      end
      else if (reg_addr == OFF_OVERRIDE)
      begin
         rd_mux[OVR_FORCE_EN_LSB +: NUM_OUT] = force_en_q;
         rd_mux[OVR_FORCE_VAL_LSB +: NUM_OUT] = force_val_q;
         rd_mux[OVR_DISARM_LSB +: NUM_OUT] = disarm_q;
      end
      else if (reg_addr == OFF_STATUS)
      begin
         rd_mux[STAT_CONTACT_LSB +: NUM_OUT] = contact;
         rd_mux[STAT_LATCH_LSB +: NUM_OUT] = latch_q;
         rd_mux[STAT_SYSOK_BIT] = system_ok_contact;
         rd_mux[STAT_DI_LSB +: NUM_DI] = di_level;
      end
      else if (reg_addr == OFF_DI_INV)
      begin
         rd_mux[NUM_DI-1:0] = di_inv_q;
      end
      else if (di_hit)
      begin
         rd_mux[TIME_W-1:0] = deb_lim_q[di_rel[2:0]];
      end
      else if (out_hit)
      begin
         if (out_sub == OUT_SLOT_OFF)
         begin
            rd_mux[SEL_W*NUM_SLOT-1:0] = slot_sel_q[out_idx[1:0]];
         end
         else if (out_sub == OUT_CFG_OFF)
         begin
            rd_mux[CFG_SLOT_INV_LSB +: NUM_SLOT] = slot_inv_q[out_idx[1:0]];
            rd_mux[CFG_COL_INV_BIT] = col_inv_q[out_idx[1:0]];
            rd_mux[CFG_LATCH_BIT] = latch_en_q[out_idx[1:0]];
            rd_mux[CFG_ACK_SEL_LSB +: SEL_W] = ack_sel_q[out_idx[1:0]];
         end
         else if (out_sub == OUT_TIME_OFF)
         begin
            rd_mux[TIME_HOLD_LSB +: TIME_W] = hold_lim_q[out_idx[1:0]];
            rd_mux[TIME_OFF_LSB +: TIME_W] = off_lim_q[out_idx[1:0]];
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n || !reg_rd)
      begin
         reg_rdata <= RST_ZERO;
      end
      else
      begin
         reg_rdata <= rd_mux;
      end
   end

endmodule : rol_relay_output

// File: bench/rol_asserts.sv
// Checker for the relay output latch block, bound to its top ports.
// Assumes TICK_LEN is handed on from the bound instance.
`timescale 1ns/1ps
module rol_asserts
   import rol_pkg::*;
#(
   parameter int TICK_LEN = 4
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // Inputs
   input wire logic [NUM_DI-1:0] di_raw,
   input wire logic boot_done,
   input wire logic internal_fault,
   input wire logic [NUM_OUT-1:0] nv_latch_in,
   // Outputs
   input wire logic [NUM_OUT-1:0] nv_latch_out,
   input wire logic [NUM_OUT-1:0] contact,
   input wire logic system_ok_contact,
   input wire logic system_ok_led,
   input wire logic [NUM_DI-1:0] di_level
);
   logic [15:0] hold_q;
   logic [11:0] ovr_q;
   logic c0_q;
   logic r0_q;
   logic [15:0] ccnt_q;
   logic [15:0] dcnt_q;
   logic ovr_wr;

   assign ovr_wr = reg_wr && reg_addr == OFF_OVERRIDE;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   // Shadow of hold time of output 0 and of the override word
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         hold_q <= 16'h0;
         ovr_q <= 12'h0;
      end
      else
      begin
         if (reg_wr && reg_addr == OFF_OUT0 + OUT_TIME_OFF)
            hold_q <= reg_wdata[15:0];
         if (ovr_wr)
            ovr_q <= reg_wdata[11:0];
      end
   end

   // Cycles since contact 0 last moved
   always_ff @(posedge ref_clk)
   begin
      c0_q <= contact[0];
      if (!reset_n || contact[0] != c0_q)
         ccnt_q <= 16'h0;
      else if (ccnt_q != 16'hffff)
         ccnt_q <= ccnt_q + 16'h1;
   end

   // Cycles since raw input 0 last toggled
   always_ff @(posedge ref_clk)
   begin
      r0_q <= di_raw[0];
      if (!reset_n || di_raw[0] != r0_q)
         dcnt_q <= 16'h0;
      else if (dcnt_q != 16'hffff)
         dcnt_q <= dcnt_q + 16'h1;
   end

   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data not zero outside read cycle");
   a_sysok_off: assert property ((!boot_done || internal_fault) |=>
      !system_ok_contact) else $error("system ok up during boot or fault");
   a_sysok_on: assert property ((boot_done && !internal_fault) [*2] |->
      system_ok_contact) else $error("system ok not up");
   a_sysok_led: assert property (system_ok_led == system_ok_contact)
      else $error("system ok indicator differs");
   a_latch_restore: assert property ($rose(reset_n) |->
      nv_latch_out == $past(nv_latch_in)) else $error("latch image lost");
   a_debounce_wait: assert property (di_level[0] != $past(di_level[0])
      && !$past(reg_wr) && !$past(reg_wr, 2) && !$past(reg_wr, 3)
      |-> dcnt_q >= 11 * TICK_LEN) else $error("input adopted too early");
   a_force_on: assert property (ovr_wr && reg_wdata[11:0] == 12'h0ff
      |-> ##[1:3] contact == 4'hf) else $error("force not applied");
   a_disarm_wins: assert property (ovr_wr && reg_wdata[OVR_DISARM_LSB]
      |-> ##[1:3] !contact[0]) else $error("disarmed contact picked up");
   a_hold_min: assert property (contact[0] != c0_q && ovr_q == 12'h0
      && hold_q != 16'h0 |-> ccnt_q + 16'h1 >= (hold_q - 16'h1) * TICK_LEN)
      else $error("contact moved before hold time");

   c_contact_up: cover property ($rose(contact[0]));
   c_sysok_up: cover property ($rose(system_ok_contact));
   c_input_up: cover property ($rose(di_level[0]));
endmodule : rol_asserts

// File: bench/rol_field_model.sv
// Field wiring: a switch on input 0 that may bounce, and an auxiliary
// contact of relay 0 wired back to input 4; other inputs pulled down.
`timescale 1ns/1ps
module rol_field_model
   import rol_pkg::*;
(
   // Clock
   input wire logic ref_clk,
   // Contacts from the block
   input wire logic [NUM_OUT-1:0] contact,
   // Switch control
   input wire logic lvl,
   input wire logic bounce,
   // Wiring into the inputs
   output logic [NUM_DI-1:0] di_raw
);
   logic chatter_q = 1'b0;

   always @(posedge ref_clk)
      chatter_q <= bounce ? ~chatter_q : lvl;

   assign di_raw = {3'h0, contact[0], 3'h0, bounce ? chatter_q : lvl};
endmodule : rol_field_model

// File: bench/testbench.sv
// Self-checking bench for the relay output latch block.
// Assumes a short tick length so debounce and hold spans stay brief.
`timescale 1ns/1ps
module testbench;
   import rol_pkg::*;
   localparam logic [7:0] SLOT0 = OFF_OUT0 + OUT_SLOT_OFF;
   localparam logic [7:0] CFG0 = OFF_OUT0 + OUT_CFG_OFF;
   localparam logic [7:0] TIME0 = OFF_OUT0 + OUT_TIME_OFF;
   logic ref_clk;
   logic reset_n;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata;
   logic [NUM_DI-1:0] di_raw;
   logic [NUM_EXT-1:0] ext_sig;
   logic panel_clear_key;
   logic global_output_ack;
   logic boot_done;
   logic internal_fault;
   logic [NUM_OUT-1:0] nv_latch_out;
   logic [NUM_OUT-1:0] contact;
   logic system_ok_contact;
   logic system_ok_led;
   logic [NUM_DI-1:0] di_level;
   logic lvl;
   logic bounce;
   int errors;
   int total_checks;

   rol_relay_output #(.TICK_LEN(4)) dut_u (.ref_clk(ref_clk),
      .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .di_raw(di_raw), .ext_sig(ext_sig), .panel_clear_key(panel_clear_key),
      .global_output_ack(global_output_ack), .boot_done(boot_done),
      .internal_fault(internal_fault), .nv_latch_in(4'h5),
      .nv_latch_out(nv_latch_out), .contact(contact),
      .system_ok_contact(system_ok_contact), .system_ok_led(system_ok_led),
      .di_level(di_level));

   rol_field_model field_u (.ref_clk(ref_clk), .contact(contact),
      .lvl(lvl), .bounce(bounce), .di_raw(di_raw));

   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask : rd

   task automatic set_ext(input logic [6:0] v);
      @(posedge ref_clk);
      ext_sig <= v;
   endtask : set_ext

   task automatic wait_c(input logic [3:0] e);
      int n;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      while (contact !== e && n < 300);
      chk({28'h0, contact}, {28'h0, e});
   endtask : wait_c

   task automatic stay_c(input int n, input logic [3:0] e);
      repeat (n) @(posedge ref_clk);
      #1;
      chk({28'h0, contact}, {28'h0, e});
   endtask : stay_c

   task automatic wait_d(input int i, input logic e);
      int n;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      while (di_level[i] !== e && n < 400);
      chk({31'h0, di_level[i]}, {31'h0, e});
   endtask : wait_d

   // Acknowledge source k: panel key, global, remote command, own signal
   task automatic ack(input int k);
      if (k == 2)
         wr(OFF_ACK_CMD, 32'h1);
      else
      begin
         @(posedge ref_clk);
         panel_clear_key <= (k == 0);
         global_output_ack <= (k == 1);
         ext_sig[1] <= (k == 3);
         repeat (8) @(posedge ref_clk);
         panel_clear_key <= 1'b0;
         global_output_ack <= 1'b0;
         ext_sig[1] <= 1'b0;
      end
   endtask : ack

   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   initial
   begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      $display("watchdog expired");
      stop_test();
   end

   initial
   begin
      errors = 0;
      total_checks = 0;
      reset_n = 1'b0;
      reg_addr = 8'h0;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      ext_sig = 7'h0;
      panel_clear_key = 1'b0;
      global_output_ack = 1'b0;
      boot_done = 1'b0;
      internal_fault = 1'b0;
      lvl = 1'b0;
      bounce = 1'b0;
      repeat (16) @(posedge ref_clk);
      reset_n <= 1'b1;
      rd(OFF_CTRL, 32'h0);
      rd(OFF_DI_DEB0, 32'h0000_000a);
      rd(TIME0, 32'h0);
      rd(OFF_STATUS, 32'h0000_0050);
      wr(8'hfc, 32'hffff_ffff);
      rd(8'hfc, 32'h0);
      chk({31'h0, system_ok_contact}, 32'h0);
      @(posedge ref_clk);
      boot_done <= 1'b1;
      stay_c(3, 4'h0);
      chk({30'h0, system_ok_contact, system_ok_led}, 32'h3);
      @(posedge ref_clk);
      internal_fault <= 1'b1;
      stay_c(3, 4'h0);
      chk({31'h0, system_ok_contact}, 32'h0);
      @(posedge ref_clk);
      internal_fault <= 1'b0;
      $display("test registers and system ok done");
      wr(SLOT0, 32'h0fed_cba9);
      for (int s = 0; s < NUM_SLOT; s++)
      begin
         set_ext(7'h1 << s);
         wait_c(4'h1);
         set_ext(7'h0);
         wait_c(4'h0);
         wr(CFG0, 32'h1 << s);
         wait_c(4'h1);
         wr(CFG0, 32'h0);
         wait_c(4'h0);
      end
      wr(CFG0, 32'h100);
      wait_c(4'h1);
      set_ext(7'h10);
      wait_c(4'h0);
      set_ext(7'h0);
      wait_c(4'h1);
      wr(SLOT0, 32'h0fed_cba0);
      wr(CFG0, 32'h1);
      wait_c(4'h0);
      wr(SLOT0, 32'h0);
      wr(CFG0, 32'h17f);
      stay_c(20, 4'h0);
      $display("test trigger combine done");
      wr(SLOT0, 32'h9);
      wr(TIME0, 32'h0002_0000);
      wr(CFG0, 32'h0000_a200);
      set_ext(7'h1);
      wait_c(4'h1);
      wait_d(4, 1'b1);
      set_ext(7'h0);
      stay_c(20, 4'h1);
      ack(1);
      ack(2);
      stay_c(30, 4'h1);
      wr(OFF_CTRL, 32'h1);
      for (int k = 0; k < 4; k++)
      begin
         if (k > 0)
         begin
            set_ext(7'h1);
            wait_c(4'h1);
            set_ext(7'h0);
            repeat (20) @(posedge ref_clk);
         end
         ack(k);
         wait_c(4'h0);
      end
      wr(TIME0, 32'h0008_0000);
      set_ext(7'h1);
      wait_c(4'h1);
      ack(2);
      stay_c(10, 4'h1);
      set_ext(7'h0);
      ack(2);
      stay_c(20, 4'h1);
      wr(CFG0, 32'h0);
      wait_c(4'h0);
      $display("test latching done");
      wr(OFF_OVERRIDE, 32'h0ff);
      wait_c(4'hf);
      wr(OFF_OVERRIDE, 32'h1ff);
      wait_c(4'he);
      wr(OFF_OVERRIDE, 32'h0);
      wait_c(4'h0);
      wr(TIME0, 32'h5);
      repeat (40) @(posedge ref_clk);
      set_ext(7'h1);
      set_ext(7'h0);
      wait_c(4'h1);
      stay_c(12, 4'h1);
      wait_c(4'h0);
      set_ext(7'h1);
      stay_c(12, 4'h0);
      wait_c(4'h1);
      set_ext(7'h0);
      wr(TIME0, 32'h0);
      $display("test override and hold done");
      wr(OFF_DI_DEB0, 32'h2);
      @(posedge ref_clk);
      lvl <= 1'b1;
      repeat (40) @(posedge ref_clk);
      #1;
      chk({31'h0, di_level[0]}, 32'h0);
      wait_d(0, 1'b1);
      @(posedge ref_clk);
      bounce <= 1'b1;
      lvl <= 1'b0;
      repeat (100) @(posedge ref_clk);
      #1;
      chk({31'h0, di_level[0]}, 32'h1);
      @(posedge ref_clk);
      bounce <= 1'b0;
      wait_d(0, 1'b0);
      wr(OFF_DI_INV, 32'h1);
      wait_d(0, 1'b1);
      $display("test inputs done");
      stop_test();
   end
endmodule : testbench

bind rol_relay_output rol_asserts #(.TICK_LEN(TICK_LEN)) asserts_u (
   .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .di_raw(di_raw), .boot_done(boot_done),
   .internal_fault(internal_fault), .nv_latch_in(nv_latch_in),
   .nv_latch_out(nv_latch_out), .contact(contact),
   .system_ok_contact(system_ok_contact), .system_ok_led(system_ok_led),
   .di_level(di_level));
